// file: rtl/bridge_cfg_pkg.sv
// constants for the bridge bus-number and secondary-status configuration registers
package bridge_cfg_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] BUS_NUM_OFF  = 8'h18;
	localparam logic [7:0] IO_STAT_OFF  = 8'h1C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int LAT_MSB      = 31;
	localparam int LAT_LSB      = 27;
	localparam int SUB_LSB      = 16;
	localparam int SEC_LSB      = 8;
	localparam int PRI_LSB      = 0;
	localparam int DEVSEL_LSB   = 25;
	localparam int FBB_BIT      = 23;
	localparam int DPAR_BIT     = 24;
	localparam int FLAG_HI_LSB  = 27;
	localparam int IO_LIM_LSB   = 12;
	localparam int IO_BASE_LSB  = 4;

	// ------------------------------------------------------------
	// fixed values and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
	localparam logic       FBB_CAPABLE   = 1'b1;
	localparam logic [7:0] BYTE_RESET    = 8'h00;
	localparam logic [3:0] NIB_RESET     = 4'h0;
	localparam logic [4:0] LAT_RESET     = 5'h00;
	localparam logic [5:0] FLAG_RESET    = 6'h00;

	// ------------------------------------------------------------
	// flag vector positions (six write-one-to-clear bits)
	// ------------------------------------------------------------
	localparam int F_PERR  = 5;
	localparam int F_SERR  = 4;
	localparam int F_MABT  = 3;
	localparam int F_TABR  = 2;
	localparam int F_TABS  = 1;
	localparam int F_DPAR  = 0;
	localparam int NFLAGS  = 6;

endpackage

// file: rtl/sec_status_if.sv
// carrier between the register bank and the secondary status flag store
`timescale 1ns/1ps
`default_nettype none
interface sec_status_if;
	logic [5:0] ev;
	logic [5:0] clr;
	logic [5:0] flags;

	modport src (output ev, output clr, input flags);
	modport dst (input ev, input clr, output flags);
endinterface
`default_nettype wire

// file: rtl/sec_status_flags.sv
// sticky write-one-to-clear secondary status flags
`timescale 1ns/1ps
`default_nettype none
module sec_status_flags
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// flag carrier
	sec_status_if.dst       st
);

	// ------------------------------------------------------------
	// flag store
	// ------------------------------------------------------------
	logic [5:0] flags_q;

	// set wins over clear so no event is lost in the clearing cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_q <= bridge_cfg_pkg::FLAG_RESET;
		else
			flags_q <= (flags_q & ~st.clr) | st.ev;
	end

	assign st.flags = flags_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	perr_set_wins_a: assert property (st.ev[bridge_cfg_pkg::F_PERR] |=> flags_q[5])
		else $error("parity flag lost its event");
	serr_sticky_a: assert property (flags_q[4] && !st.clr[4] |=> flags_q[4])
		else $error("system error flag dropped without clear");
	abort_clear_a: assert property (st.clr[3:1] == 3'h7 && st.ev[3:1] == 3'h0 |=> flags_q[3:1] == 3'h0)
		else $error("abort flags not cleared by write of one");
	tabr_set_a: assert property (st.ev[2] && st.clr[2] |=> flags_q[2])
		else $error("target abort received flag lost");
	tabs_set_a: assert property (!flags_q[1] && st.ev[1] |=> flags_q[1])
		else $error("signalled target abort flag not set");

	clear_race_c: cover property (st.ev[5] && st.clr[5]);

endmodule
`default_nettype wire

// file: rtl/bridge_bus_numbers_secondary_status.sv
// bus number, secondary latency, i/o window and secondary status configuration registers
`timescale 1ns/1ps
`default_nettype none
module bridge_bus_numbers_secondary_status
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// configuration access from the primary side
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata_q,
	output logic             cfg_rvalid_q,
	// primary type 1 configuration decode
	input  wire logic        p_cfg1_valid,
	input  wire logic [7:0]  p_cfg1_bus,
	output logic             sec_tgt_q,
	output logic             sub_fwd_q,
	// secondary type 1 configuration decode
	input  wire logic        s_cfg1_valid,
	input  wire logic [7:0]  s_cfg1_bus,
	output logic             spec_cyc_q,
	// primary i/o decode
	input  wire logic        p_io_valid,
	input  wire logic [31:0] p_io_addr,
	output logic             io_fwd_q,
	// secondary bus events and controls
	input  wire logic        s_par_resp_en,
	input  wire logic        s_par_err,
	input  wire logic        s_serr_seen,
	input  wire logic        s_master_abort,
	input  wire logic        s_tabort_rcvd,
	input  wire logic        s_tabort_sig,
	input  wire logic        s_master_perr,
	// secondary master latency
	input  wire logic        s_frame_act,
	input  wire logic        s_gnt,
	output logic             lat_expired_q,
	output logic             burst_stop_q
);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [4:0] lat_hi_q;
	logic [7:0] sub_q;
	logic [7:0] sec_q;
	logic [7:0] pri_q;
	logic [3:0] io_lim_q;
	logic [3:0] io_base_q;
	logic [7:0] lat_val;
	logic       wr_bus;
	logic       wr_io;

	sec_status_if st ();

	assign lat_val = {lat_hi_q, 3'h0};
	assign wr_bus  = cfg_wr && (cfg_addr == bridge_cfg_pkg::BUS_NUM_OFF);
	assign wr_io   = cfg_wr && (cfg_addr == bridge_cfg_pkg::IO_STAT_OFF);

	// ------------------------------------------------------------
	// bus numbers and latency writes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lat_hi_q <= bridge_cfg_pkg::LAT_RESET;
			sub_q    <= bridge_cfg_pkg::BYTE_RESET;
			sec_q    <= bridge_cfg_pkg::BYTE_RESET;
			pri_q    <= bridge_cfg_pkg::BYTE_RESET;
		end
		else if (wr_bus)
		begin
			if (cfg_be[3])
				lat_hi_q <= cfg_wdata[bridge_cfg_pkg::LAT_MSB:bridge_cfg_pkg::LAT_LSB];
			if (cfg_be[2])
				sub_q <= cfg_wdata[bridge_cfg_pkg::SUB_LSB +: 8];
			if (cfg_be[1])
				sec_q <= cfg_wdata[bridge_cfg_pkg::SEC_LSB +: 8];
			if (cfg_be[0])
				pri_q <= cfg_wdata[bridge_cfg_pkg::PRI_LSB +: 8];
		end
	end

	// ------------------------------------------------------------
	// i/o window writes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			io_lim_q  <= bridge_cfg_pkg::NIB_RESET;
			io_base_q <= bridge_cfg_pkg::NIB_RESET;
		end
		else if (wr_io)
		begin
			if (cfg_be[1])
				io_lim_q <= cfg_wdata[bridge_cfg_pkg::IO_LIM_LSB +: 4];
			if (cfg_be[0])
				io_base_q <= cfg_wdata[bridge_cfg_pkg::IO_BASE_LSB +: 4];
		end
	end

	// ------------------------------------------------------------
	// status flag events and clears
	// ------------------------------------------------------------
	always_comb
	begin
		st.ev         = '0;
		st.ev[bridge_cfg_pkg::F_PERR] = s_par_err;
		st.ev[bridge_cfg_pkg::F_SERR] = s_serr_seen;
		st.ev[bridge_cfg_pkg::F_MABT] = s_master_abort;
		st.ev[bridge_cfg_pkg::F_TABR] = s_tabort_rcvd;
		st.ev[bridge_cfg_pkg::F_TABS] = s_tabort_sig;
		st.ev[bridge_cfg_pkg::F_DPAR] = s_par_resp_en && (s_master_perr || s_par_err);
		st.clr        = '0;
		if (wr_io && cfg_be[3])
			st.clr = {cfg_wdata[31:27], cfg_wdata[bridge_cfg_pkg::DPAR_BIT]};
	end

	sec_status_flags u_flags
	(
		.clk   (clk),
		.rst_n (rst_n),
		.st    (st)
	);

	// ------------------------------------------------------------
	// configuration read
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_rdata_q  <= 32'h0000_0000;
			cfg_rvalid_q <= 1'b0;
		end
		else
		begin
			cfg_rvalid_q <= cfg_rd;
			if (!cfg_rd)
				cfg_rdata_q <= 32'h0000_0000;
			else if (cfg_addr == bridge_cfg_pkg::BUS_NUM_OFF)
				cfg_rdata_q <= {lat_val, sub_q, sec_q, pri_q};
			else if (cfg_addr == bridge_cfg_pkg::IO_STAT_OFF)
				cfg_rdata_q <= {st.flags[5:1], bridge_cfg_pkg::DEVSEL_MEDIUM,
					st.flags[0], bridge_cfg_pkg::FBB_CAPABLE, 7'h00,
					io_lim_q, 4'h0, io_base_q, 4'h0};
			else
				cfg_rdata_q <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// configuration and i/o decode
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sec_tgt_q  <= 1'b0;
			sub_fwd_q  <= 1'b0;
			spec_cyc_q <= 1'b0;
			io_fwd_q   <= 1'b0;
		end
		else
		begin
			sec_tgt_q  <= p_cfg1_valid && (p_cfg1_bus == sec_q);
			sub_fwd_q  <= p_cfg1_valid && (p_cfg1_bus > sec_q) && (p_cfg1_bus <= sub_q);
			spec_cyc_q <= s_cfg1_valid && (s_cfg1_bus == pri_q);
			// limit is inclusive with the low twelve address bits taken as ones
			io_fwd_q   <= p_io_valid && (p_io_addr[31:16] == 16'h0000)
				&& (p_io_addr[15:12] >= io_base_q) && (p_io_addr[15:12] <= io_lim_q);
		end
	end

	// ------------------------------------------------------------
	// secondary master latency timer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {T_IDLE, T_RUN, T_EXP} tmr_state_e;
	tmr_state_e tmr_q;
	logic [7:0] cnt_q;

	// limit is compared live, so reprogramming it mid-burst moves the current expiry point
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tmr_q         <= T_IDLE;
			cnt_q         <= 8'h00;
			lat_expired_q <= 1'b0;
		end
		else
		begin
			case (tmr_q)
				T_IDLE:
				begin
					lat_expired_q <= 1'b0;
					if (s_frame_act && (lat_val != 8'h00))
					begin
						tmr_q <= T_RUN;
						cnt_q <= 8'h01;
					end
				end
				T_RUN:
				begin
					if (!s_frame_act)
						tmr_q <= T_IDLE;
					else if (cnt_q >= lat_val)
					begin
						tmr_q         <= T_EXP;
						lat_expired_q <= 1'b1;
					end
					else
						cnt_q <= cnt_q + 8'h01;
				end
				default:
				begin
					if (!s_frame_act)
					begin
						tmr_q         <= T_IDLE;
						lat_expired_q <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			burst_stop_q <= 1'b0;
		else
			burst_stop_q <= lat_expired_q && s_frame_act && !s_gnt;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	lat_low_zero_a: assert property (cfg_rd && cfg_addr == 8'h18 |=> cfg_rdata_q[26:24] == 3'h0)
		else $error("latency low bits not zero");
	lat_off_a: assert property (lat_val == 8'h00 && tmr_q == T_IDLE |=> !lat_expired_q)
		else $error("timer active with zero limit");
	lat_expire_a: assert property ((tmr_q == T_IDLE && s_frame_act && lat_val == 8'h08 && !cfg_wr)
		##1 (s_frame_act && !cfg_wr) [*8] |=> lat_expired_q)
		else $error("timer did not expire after eight clocks");
	sec_match_a: assert property (p_cfg1_valid && p_cfg1_bus == sec_q |=> sec_tgt_q && !sub_fwd_q)
		else $error("secondary bus match wrong");
	sub_range_a: assert property (p_cfg1_valid && p_cfg1_bus > sec_q && p_cfg1_bus <= sub_q
		|=> sub_fwd_q)
		else $error("subordinate range not forwarded");
	sub_above_a: assert property (p_cfg1_valid && p_cfg1_bus > sub_q |=> !sub_fwd_q)
		else $error("bus above subordinate forwarded");
	spec_cyc_a: assert property (s_cfg1_valid && s_cfg1_bus == pri_q |=> spec_cyc_q)
		else $error("primary bus match missed");
	status_fixed_a: assert property (cfg_rd && cfg_addr == 8'h1C
		|=> cfg_rdata_q[26:25] == 2'h1 && cfg_rdata_q[23] && cfg_rdata_q[11:8] == 4'h0)
		else $error("fixed status fields wrong");
	dpar_flag_a: assert property (s_par_resp_en && (s_master_perr || s_par_err) |=> st.flags[0])
		else $error("data parity flag not set");
	io_window_a: assert property (p_io_valid && p_io_addr[31:16] != 16'h0000 |=> !io_fwd_q)
		else $error("i/o above 64k forwarded");
	burst_stop_a: assert property (lat_expired_q && s_frame_act && !s_gnt |=> burst_stop_q)
		else $error("burst not stopped");

	expire_c: cover property (lat_expired_q && !s_gnt);
	sub_fwd_c: cover property (sub_fwd_q);
	io_fwd_c: cover property (io_fwd_q);

endmodule
`default_nettype wire

// file: verif/sec_bus_agent.sv
// behavioural secondary bus agents: event pulses, frame and grant
`timescale 1ns/1ps
`default_nettype none
module sec_bus_agent
(
	// clock
	input  wire logic       clk,
	// secondary bus events and arbitration
	output logic      [5:0] ev,
	output logic            frame_act,
	output logic            gnt
);
	// ------------------------------------------------------------
	// idle: no events, no frame, grant parked on the bridge
	// ------------------------------------------------------------
	initial
	begin
		ev        = 6'h00;
		frame_act = 1'b0;
		gnt       = 1'b1;
	end

	// ------------------------------------------------------------
	// driven on the falling edge, so the bridge samples settled levels
	// ------------------------------------------------------------
	task automatic pulse(input int idx);
	begin
		ev[idx] = 1'b1;
		@(negedge clk);
		ev = 6'h00;
	end
	endtask

	task automatic set_frame(input logic f, input logic g);
	begin
		frame_act = f;
		gnt       = g;
	end
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the bus number and secondary status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, rst_n, cfg_wr, cfg_rd, p_cfg1_valid, s_cfg1_valid, p_io_valid;
	logic        s_par_resp_en;
	logic [7:0]  cfg_addr, p_cfg1_bus, s_cfg1_bus;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, p_io_addr;
	wire  logic [31:0] cfg_rdata_q;
	wire  logic        cfg_rvalid_q, sec_tgt_q, sub_fwd_q, spec_cyc_q, io_fwd_q;
	wire  logic        lat_expired_q, burst_stop_q, frame_act, gnt;
	wire  logic [5:0]  ev;
	int          err_total, comparisons;

	sec_bus_agent agent (.clk(clk), .ev(ev), .frame_act(frame_act), .gnt(gnt));

	bridge_bus_numbers_secondary_status uut (
		.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
		.cfg_rvalid_q(cfg_rvalid_q), .p_cfg1_valid(p_cfg1_valid), .p_cfg1_bus(p_cfg1_bus),
		.sec_tgt_q(sec_tgt_q), .sub_fwd_q(sub_fwd_q), .s_cfg1_valid(s_cfg1_valid),
		.s_cfg1_bus(s_cfg1_bus), .spec_cyc_q(spec_cyc_q), .p_io_valid(p_io_valid),
		.p_io_addr(p_io_addr), .io_fwd_q(io_fwd_q), .s_par_resp_en(s_par_resp_en),
		.s_par_err(ev[bridge_cfg_pkg::F_PERR]), .s_serr_seen(ev[bridge_cfg_pkg::F_SERR]),
		.s_master_abort(ev[bridge_cfg_pkg::F_MABT]), .s_tabort_rcvd(ev[bridge_cfg_pkg::F_TABR]),
		.s_tabort_sig(ev[bridge_cfg_pkg::F_TABS]), .s_master_perr(ev[bridge_cfg_pkg::F_DPAR]),
		.s_frame_act(frame_act), .s_gnt(gnt), .lat_expired_q(lat_expired_q),
		.burst_stop_q(burst_stop_q));

	// ------------------------------------------------------------
	// clock, compare, access and closing tasks
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
	begin
		cfg_addr  = a;
		cfg_be    = be;
		cfg_wdata = d;
		cfg_wr    = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	end
	endtask

	// read data stands one cycle only, so it is compared at the next falling edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
	begin
		cfg_addr = a;
		cfg_rd   = 1'b1;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk_bit(cfg_rvalid_q, 1'b1);
		chk_word(cfg_rdata_q, exp);
	end
	endtask

	task automatic end_sim;
	begin
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	// ------------------------------------------------------------
	// watchdog: the tests need well under a thousand cycles
	// ------------------------------------------------------------
	initial
	begin
		#40000;
		err_total++;
		end_sim();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0] io_tab [5];
		io_tab = '{32'h0000_1FFF, 32'h0000_2000, 32'h0000_4FFF, 32'h0000_5000, 32'h1000_3000};
		err_total = 0;
		comparisons = 0;
		{cfg_wr, cfg_rd, p_cfg1_valid, s_cfg1_valid, p_io_valid, s_par_resp_en} = 6'h00;
		{cfg_addr, p_cfg1_bus, s_cfg1_bus, cfg_be} = 28'h0;
		{cfg_wdata, p_io_addr} = 64'h0;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd_chk(bridge_cfg_pkg::BUS_NUM_OFF, 32'h0000_0000);
		@(negedge clk);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_0000);
		cfg_write(8'h20, 4'hF, 32'hFFFF_FFFF);
		rd_chk(8'h20, 32'h0000_0000);
		cfg_write(bridge_cfg_pkg::BUS_NUM_OFF, 4'hF, 32'hFFFF_FFFF);
		rd_chk(bridge_cfg_pkg::BUS_NUM_OFF, 32'hF8FF_FFFF);
		cfg_write(bridge_cfg_pkg::BUS_NUM_OFF, 4'h1, 32'h0000_0000);
		rd_chk(bridge_cfg_pkg::BUS_NUM_OFF, 32'hF8FF_FF00);
		cfg_write(bridge_cfg_pkg::IO_STAT_OFF, 4'hF, 32'h0000_FFFF);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_F0F0);
		$display("test registers done");
		// primary 1, secondary 2, subordinate 5
		cfg_write(bridge_cfg_pkg::BUS_NUM_OFF, 4'hF, 32'h0005_0201);
		p_cfg1_valid = 1'b1;
		s_cfg1_valid = 1'b1;
		for (int b = 0; b < 7; b++)
		begin
			p_cfg1_bus = b[7:0];
			s_cfg1_bus = b[7:0];
			@(negedge clk);
			chk_bit(sec_tgt_q, b == 2);
			chk_bit(sub_fwd_q, b > 2 && b <= 5);
			chk_bit(spec_cyc_q, b == 1);
		end
		p_cfg1_valid = 1'b0;
		s_cfg1_valid = 1'b0;
		$display("test bus numbers done");
		// i/o window 0x2000..0x4FFF
		cfg_write(bridge_cfg_pkg::IO_STAT_OFF, 4'h3, 32'h0000_4020);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_4020);
		p_io_valid = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			p_io_addr = io_tab[i];
			@(negedge clk);
			chk_bit(io_fwd_q, io_tab[i][31:16] == 16'h0 && io_tab[i][15:12] >= 4'h2
				&& io_tab[i][15:12] <= 4'h4);
		end
		p_io_valid = 1'b0;
		$display("test io window done");
		// flags other than data parity with parity response off, then data parity with it off and on
		for (int i = 1; i < 6; i++)
		begin
			agent.pulse(i);
			cfg_write(bridge_cfg_pkg::IO_STAT_OFF, 4'h8, 32'h0000_0000);
			rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_4020 | (32'h1 << (26 + i)));
			cfg_write(bridge_cfg_pkg::IO_STAT_OFF, 4'h8, 32'hFF00_0000);
			rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_4020);
		end
		agent.pulse(0);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_4020);
		s_par_resp_en = 1'b1;
		agent.pulse(0);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0380_4020);
		cfg_write(bridge_cfg_pkg::IO_STAT_OFF, 4'h8, 32'hFF00_0000);
		agent.pulse(5);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h8380_4020);
		cfg_write(bridge_cfg_pkg::IO_STAT_OFF, 4'h8, 32'hFF00_0000);
		rd_chk(bridge_cfg_pkg::IO_STAT_OFF, 32'h0280_4020);
		$display("test status flags done");
		// latency limit of eight clocks
		cfg_write(bridge_cfg_pkg::BUS_NUM_OFF, 4'h8, 32'h0800_0000);
		agent.set_frame(1'b1, 1'b1);
		repeat (8) @(negedge clk);
		chk_bit(lat_expired_q, 1'b0);
		@(negedge clk);
		chk_bit(lat_expired_q, 1'b1);
		chk_bit(burst_stop_q, 1'b0);
		agent.set_frame(1'b1, 1'b0);
		@(negedge clk);
		chk_bit(burst_stop_q, 1'b1);
		agent.set_frame(1'b0, 1'b1);
		repeat (2) @(negedge clk);
		chk_bit(lat_expired_q, 1'b0);
		cfg_write(bridge_cfg_pkg::BUS_NUM_OFF, 4'h8, 32'h0000_0000);
		agent.set_frame(1'b1, 1'b0);
		repeat (40) @(negedge clk);
		chk_bit(lat_expired_q, 1'b0);
		chk_bit(burst_stop_q, 1'b0);
		agent.set_frame(1'b0, 1'b1);
		$display("test latency timer done");
		end_sim();
	end
endmodule
`default_nettype wire
